// [sasr_defs.svh]
// Constants for the sync status and system alarm register group.
`ifndef SASR_DEFS_SVH
`define SASR_DEFS_SVH

// Register offsets on the serial control port (15-bit address space).
`define SASR_OFF_TEMP_PWR 15'h0401
`define SASR_OFF_SYNC 15'h0410
`define SASR_OFF_ALARM 15'h0430
`define SASR_OFF_MASK 15'h0431

// Reset values.
`define SASR_RST_TEMP_PWR 8'h00
`define SASR_RST_MASK 8'h00
`define SASR_RST_SYNC 8'h00
`define SASR_RST_ALARM 8'h02
`define SASR_RST_BYTE 8'h00

// Field positions of the sync status register.
`define SASR_SYNC_REF_SEEN 0
`define SASR_SYNC_OSC_SEEN 1
`define SASR_SYNC_CONSISTENT 2
`define SASR_SYNC_REALIGNED 3

// Field positions of the alarm and mask registers.
`define SASR_ALM_MISALIGN 0
`define SASR_ALM_CHIP_RST 1
`define SASR_ALM_LANE_CHECK 5
`define SASR_ALM_LINK_TIMER 6
`define SASR_ALM_LINK_DOWN 7

// Sleep control position in the temperature sensor power register.
`define SASR_TEMP_SLEEP 0

// Bits that hold state, bits that write-1-to-clear, and mask bits that gate.
`define SASR_SYNC_STICKY 8'h0b
`define SASR_ALM_STICKY 8'he3
`define SASR_MASK_LIVE 8'he1

// Serial frame: one direction bit, 15 address bits, 8 data bits.
`define SASR_CNT_ADDR_LAST 5'd15
`define SASR_CNT_DATA_LAST 5'd23
`define SASR_CNT_FRAME 5'd24
`define SASR_CNT_ONE 5'd1
`define SASR_CNT_ZERO 5'd0
`define SASR_DIR_BIT 14

// Pin positions inside the input filter vector.
`define SASR_PIN_SCLK 0
`define SASR_PIN_CS_B 1
`define SASR_PIN_SDI 2
`define SASR_PIN_COUNT 3
`define SASR_RST_PINS 3'h2

`endif

// [sasr_pkg.sv]
// Types shared by the sync status and system alarm register group.
`default_nettype none
package sasr_pkg;

   // One register access decoded from a serial frame.
   typedef struct packed {
      logic wr;
      logic rd;
      logic [14:0] addr;
      logic [7:0] data;
   } sasr_req_s;

   // Frame phase, Gray coded along idle, address, data.
   typedef enum logic [1:0] {
      SASR_IDLE = 2'b00,
      SASR_ADDR = 2'b01,
      SASR_DATA = 2'b11
   } sasr_phase_e;

endpackage : sasr_pkg
`default_nettype wire

// [sasr_sticky_flags.sv]
// Sticky status byte with write-1-to-clear and set priority.
`timescale 1ns/1ps
`default_nettype none
module sasr_sticky_flags #(
   parameter logic [7:0] RST_VAL = 8'h00
) (
   input wire logic clk_in, // Core clock.
   input wire logic rst_b_in, // Synchronous reset, active low.
   input wire logic [7:0] set_in, // Hardware set events, one cycle each.
   input wire logic [7:0] clr_in, // Software write-1 clear strobes.
   input wire logic [7:0] keep_in, // Bits that hold state at all.
   output logic [7:0] flags_out // Current flag byte.
);

   logic [7:0] flags_ff;
   logic [7:0] nxt_flags;

   // set beats clear
   // A set in the clearing cycle survives, so no event is lost.
   assign nxt_flags = ((flags_ff & ~clr_in) | set_in) & keep_in;

   // Flag storage.
   always_ff @(posedge clk_in)
   begin
      if (!rst_b_in)
      begin
         flags_ff <= RST_VAL;
      end
      else
      begin
         flags_ff <= nxt_flags;
      end
   end

   assign flags_out = flags_ff;

endmodule : sasr_sticky_flags
`default_nettype wire

// [sasr_serial_port.sv]
// Serial control port framer: 24-bit frames to register accesses.
`timescale 1ns/1ps
`default_nettype none
`include "sasr_defs.svh"
module sasr_serial_port (
   input wire logic clk_in, // Core clock.
   input wire logic rst_b_in, // Synchronous reset, active low.
   input wire logic cs_b_in, // Filtered chip select, active low.
   input wire logic sclk_rise_in, // Filtered serial clock rising edge.
   input wire logic sclk_fall_in, // Filtered serial clock falling edge.
   input wire logic sdi_in, // Filtered serial data in.
   input wire logic [7:0] rd_data_in, // Read byte for the current address.
   output sasr_pkg::sasr_req_s req_out, // Access request, strobes one cycle.
   output logic sdo_out, // Serial data out.
   output logic sdo_oe_out // Serial data out drive enable.
);

   sasr_pkg::sasr_phase_e phase_ff;
   sasr_pkg::sasr_req_s req_ff;
   logic [4:0] cnt_ff;
   logic [15:0] in_sh_ff;
   logic [7:0] out_sh_ff;
   logic dir_rd_ff;
   logic sdo_ff;
   logic oe_ff;
   logic take;
   logic [15:0] nxt_in_sh;

   // A bit is taken on each rising edge while selected and not yet full.
   assign take = sclk_rise_in && !cs_b_in && (cnt_ff != `SASR_CNT_FRAME);
   assign nxt_in_sh = {in_sh_ff[14:0], sdi_in};

   // Frame tracking; bits past the 24th are ignored.
   always_ff @(posedge clk_in)
   begin
      if (!rst_b_in || cs_b_in)
      begin
         phase_ff <= sasr_pkg::SASR_IDLE;
         cnt_ff <= `SASR_CNT_ZERO;
         in_sh_ff <= 16'h0000;
         dir_rd_ff <= 1'b0;
         req_ff <= '0;
      end
      else
      begin
         req_ff.rd <= 1'b0;
         req_ff.wr <= 1'b0;
         case (phase_ff)
            sasr_pkg::SASR_IDLE: phase_ff <= sasr_pkg::SASR_ADDR;
            sasr_pkg::SASR_ADDR:
            begin
               if (take && cnt_ff == `SASR_CNT_ADDR_LAST)
               begin
                  phase_ff <= sasr_pkg::SASR_DATA;
                  dir_rd_ff <= in_sh_ff[`SASR_DIR_BIT];
                  req_ff.addr <= nxt_in_sh[14:0];
                  req_ff.rd <= in_sh_ff[`SASR_DIR_BIT];
               end
            end
            sasr_pkg::SASR_DATA:
            begin
               if (take && cnt_ff == `SASR_CNT_DATA_LAST && !dir_rd_ff)
               begin
                  req_ff.data <= nxt_in_sh[7:0];
                  req_ff.wr <= 1'b1;
               end
            end
            default: phase_ff <= sasr_pkg::SASR_IDLE;
         endcase
         if (take)
         begin
            cnt_ff <= cnt_ff + `SASR_CNT_ONE;
            in_sh_ff <= nxt_in_sh;
         end
      end
   end

   // Read data is loaded one cycle after the address and shifted on falling edges.
   always_ff @(posedge clk_in)
   begin
      if (!rst_b_in || cs_b_in)
      begin
         out_sh_ff <= `SASR_RST_BYTE;
         sdo_ff <= 1'b0;
         oe_ff <= 1'b0;
      end
      else
      begin
         oe_ff <= dir_rd_ff && (phase_ff == sasr_pkg::SASR_DATA);
         if (req_ff.rd)
         begin
            out_sh_ff <= rd_data_in;
         end
         else if (sclk_fall_in && oe_ff)
         begin
            sdo_ff <= out_sh_ff[7];
            out_sh_ff <= {out_sh_ff[6:0], 1'b0};
         end
      end
   end

   assign req_out = req_ff;
   assign sdo_out = sdo_ff;
   assign sdo_oe_out = oe_ff;

endmodule : sasr_serial_port
`default_nettype wire

// [sasr_sync_alarm_regs.sv]
// Sync status and system alarm registers behind the serial control port.
//
// Functional notes
// - Sleep bit 1 sleeps the temperature sensor; 0, the reset value, keeps converting.
// - Sync bit 3 sticks on divider realignment to the reference, cleared by writing 1.
// - Sync bit 2 is read-only: last reference pulse matched the dividers.
// - Sync bit 1 sticks when any oscillator gets a sync event; write 1 clears.
// - Sync bit 0 sticks on reference detection; write 1 clears and re-arms it.
// - Alarm bit 7 holds link-down, only while link enabled; write 1 clears.
// - Alarm bit 5 sticks on lane check faults, enabled lanes, 64b/66b only.
// - Alarm bit 1 sets on any chip reset; write 1 clears.
// - Alarm bit 0 sets on reference misalignment from dividers or enabled link.
// - Mask bit 7 keeps link-down off the alarm output.
// - The alarm mask resets to zero, so every alarm reaches the output.
// - Mask bit 5 keeps the lane check alarm off the alarm output.
// - Mask bit 0 keeps the misalignment alarm off the alarm output.
// - Mask bit 6 keeps the link timer alarm off the alarm output.
`timescale 1ns/1ps
`default_nettype none
`include "sasr_defs.svh"
module sasr_sync_alarm_regs (
   input wire logic clk_in, // Core clock, 250 MHz.
   input wire logic rst_b_in, // Reset pin or power-on, synchronous, low.
   input wire logic soft_reset_in, // Software reset command, one cycle.
   input wire logic sclk_in, // Serial port clock pin.
   input wire logic cs_b_in, // Serial port chip select pin, low.
   input wire logic sdi_in, // Serial port data in pin.
   input wire logic div_realign_in, // Reference dividers realigned, pulse.
   input wire logic ref_pulse_in, // Reference pulse detected, pulse.
   input wire logic ref_match_in, // Pulse agreed with dividers, with pulse.
   input wire logic [3:0] osc_sync_in, // Per-oscillator sync event, pulse.
   input wire logic link_enable_in, // Serial link enabled, level.
   input wire logic link_down_in, // Link down seen, level or pulse.
   input wire logic link_timer_in, // Link timer expired, pulse.
   input wire logic [15:0] lane_enable_in, // Enabled lanes, level.
   input wire logic [15:0] lane_fault_in, // Per-lane check fault, pulse.
   input wire logic mode_64b66b_in, // Link runs 64b/66b coding, level.
   input wire logic div_misalign_in, // Dividers saw misaligned edge, pulse.
   input wire logic link_misalign_in, // Link saw misaligned edge, pulse.
   output logic sdo_out, // Serial port data out.
   output logic sdo_oe_out, // Serial data out drive enable, high drives.
   output logic temp_sensor_sleep_out, // Temperature sensor sleep, high.
   output logic alarm_out // Alarm output, high while unmasked alarm.
);

   // ==========================================================================
   // Address decode helper
   // ==========================================================================

   // One compare serves read select and write strobes for every register.
   function automatic logic sasr_hit(input logic [14:0] addr, input logic [14:0] off);
      sasr_hit = (addr == off);
   endfunction : sasr_hit

   // ==========================================================================
   // Declarations
   // ==========================================================================

   logic block_rst_b;
   logic [2:0] pin_meta_ff [`SASR_PIN_COUNT];
   logic [2:0] pin_filt_ff;
   logic [2:0] pin_prev_ff;
   logic sclk_rise;
   logic sclk_fall;
   sasr_pkg::sasr_req_s req;
   logic [7:0] rd_byte;
   logic hit_temp;
   logic hit_sync;
   logic hit_alarm;
   logic hit_mask;
   logic wr_temp;
   logic wr_mask;
   logic [7:0] sync_clr;
   logic [7:0] alarm_clr;
   logic [7:0] sync_set;
   logic [7:0] alarm_set;
   logic [7:0] sync_q;
   logic [7:0] alarm_q;
   logic [7:0] sync_read;
   logic [7:0] temp_pwr_ff;
   logic [7:0] mask_ff;
   logic consistent_ff;
   logic alarm_ff;
   logic [7:0] live_alarms;
   logic lane_fault_any;
   logic misalign_any;
   logic link_down_q;

   // The software reset returns the registers to their reset state, like the pin, but not the port or pin filters.
   assign block_rst_b = rst_b_in && !soft_reset_in;

   // ==========================================================================
   // Pin filters
   // ==========================================================================

   // Three flops per pin; a level counts only once the second and third agree,
   // which also rejects a single-cycle glitch on a slow serial clock.
   always_ff @(posedge clk_in)
   begin
      for (int i = 0; i < `SASR_PIN_COUNT; i++)
      begin
         pin_meta_ff[i] <= {pin_meta_ff[i][1:0], (i == `SASR_PIN_SCLK) ? sclk_in :
                            (i == `SASR_PIN_CS_B) ? cs_b_in : sdi_in};
      end
   end

   // Filtered levels; chip select idles high so a reset frame is not started.
   always_ff @(posedge clk_in)
   begin
      if (!rst_b_in)
      begin
         pin_filt_ff <= `SASR_RST_PINS;
         pin_prev_ff <= `SASR_RST_PINS;
      end
      else
      begin
         for (int i = 0; i < `SASR_PIN_COUNT; i++)
         begin
            if (pin_meta_ff[i][1] == pin_meta_ff[i][2])
            begin
               pin_filt_ff[i] <= pin_meta_ff[i][2];
            end
         end
         pin_prev_ff <= pin_filt_ff;
      end
   end

   // Serial clock edges seen in the core clock domain.
   assign sclk_rise = pin_filt_ff[`SASR_PIN_SCLK] && !pin_prev_ff[`SASR_PIN_SCLK];
   assign sclk_fall = !pin_filt_ff[`SASR_PIN_SCLK] && pin_prev_ff[`SASR_PIN_SCLK];

   // ==========================================================================
   // Serial control port
   // ==========================================================================

   // The port itself is not cleared by the software reset, so the frame that
   // carries the reset command ends cleanly.
   sasr_serial_port u_port (
      .clk_in(clk_in),
      .rst_b_in(rst_b_in),
      .cs_b_in(pin_filt_ff[`SASR_PIN_CS_B]),
      .sclk_rise_in(sclk_rise),
      .sclk_fall_in(sclk_fall),
      .sdi_in(pin_filt_ff[`SASR_PIN_SDI]),
      .rd_data_in(rd_byte),
      .req_out(req),
      .sdo_out(sdo_out),
      .sdo_oe_out(sdo_oe_out)
   );

   // ==========================================================================
   // Address decode and write strobes
   // ==========================================================================

   // Register selects.
   assign hit_temp = sasr_hit(req.addr, `SASR_OFF_TEMP_PWR);
   assign hit_sync = sasr_hit(req.addr, `SASR_OFF_SYNC);
   assign hit_alarm = sasr_hit(req.addr, `SASR_OFF_ALARM);
   assign hit_mask = sasr_hit(req.addr, `SASR_OFF_MASK);

   // Plain read/write stores.
   assign wr_temp = req.wr && hit_temp;
   assign wr_mask = req.wr && hit_mask;

   // read-only bit kept
   // Clear strobes only reach sticky bits; bit 2 and reserved bits ignore writes.
   assign sync_clr = (req.wr && hit_sync) ? (req.data & `SASR_SYNC_STICKY) : 8'h00;

   // reserved bits ignored
   // Alarm bits 4 to 2 never see a clear or a set and read as zero.
   assign alarm_clr = (req.wr && hit_alarm) ? (req.data & `SASR_ALM_STICKY) : 8'h00;

   // ==========================================================================
   // Control registers
   // ==========================================================================

   // mask resets clear
   // The whole sleep byte is stored; only bit 0 steers the sensor.
   always_ff @(posedge clk_in)
   begin
      if (!block_rst_b)
      begin
         temp_pwr_ff <= `SASR_RST_TEMP_PWR;
         mask_ff <= `SASR_RST_MASK;
      end
      else
      begin
         if (wr_temp)
         begin
            temp_pwr_ff <= req.data;
         end
         if (wr_mask)
         begin
            mask_ff <= req.data;
         end
      end
   end

   assign temp_sensor_sleep_out = temp_pwr_ff[`SASR_TEMP_SLEEP];

   // ==========================================================================
   // Sync status
   // ==========================================================================

   // last pulse consistency
   // Tracks the most recent reference pulse only; it holds between pulses.
   always_ff @(posedge clk_in)
   begin
      if (!block_rst_b)
      begin
         consistent_ff <= 1'b0;
      end
      else if (ref_pulse_in)
      begin
         consistent_ff <= ref_match_in;
      end
   end

   always_comb
   begin
      sync_set = 8'h00;
      sync_set[`SASR_SYNC_REALIGNED] = div_realign_in;
      sync_set[`SASR_SYNC_OSC_SEEN] = |osc_sync_in;
      sync_set[`SASR_SYNC_REF_SEEN] = ref_pulse_in;
   end

   // Sticky sync flags.
   sasr_sticky_flags #(
      .RST_VAL(`SASR_RST_SYNC)
   ) u_sync_flags (
      .clk_in(clk_in),
      .rst_b_in(block_rst_b),
      .set_in(sync_set),
      .clr_in(sync_clr),
      .keep_in(`SASR_SYNC_STICKY),
      .flags_out(sync_q)
   );

   // The consistency bit is merged into the read image, not stored as sticky.
   always_comb
   begin
      sync_read = sync_q;
      sync_read[`SASR_SYNC_CONSISTENT] = consistent_ff;
   end

   // ==========================================================================
   // System alarms
   // ==========================================================================

   // lane check qualify
   // Faults on disabled lanes, or outside 64b/66b coding, are not alarms.
   assign lane_fault_any = mode_64b66b_in && |(lane_fault_in & lane_enable_in);

   // misalignment sources
   // The link's report counts only while the link is enabled.
   assign misalign_any = div_misalign_in || (link_misalign_in && link_enable_in);

   assign link_down_q = link_down_in && link_enable_in;

   // Set events for the alarm byte; the chip reset alarm is preset by reset.
   always_comb
   begin
      alarm_set = 8'h00;
      alarm_set[`SASR_ALM_LINK_DOWN] = link_down_q;
      alarm_set[`SASR_ALM_LINK_TIMER] = link_timer_in;
      alarm_set[`SASR_ALM_LANE_CHECK] = lane_fault_any;
      alarm_set[`SASR_ALM_MISALIGN] = misalign_any;
   end

   // reset presets alarm
   // Reset value carries bit 1, so every pin, power-on or software reset leaves it set.
   sasr_sticky_flags #(
      .RST_VAL(`SASR_RST_ALARM)
   ) u_alarm_flags (
      .clk_in(clk_in),
      .rst_b_in(block_rst_b),
      .set_in(alarm_set),
      .clr_in(alarm_clr),
      .keep_in(`SASR_ALM_STICKY),
      .flags_out(alarm_q)
   );

   // ==========================================================================
   // Alarm output
   // ==========================================================================

   // alarm mask
   // Only the four defined mask bits gate; reserved mask bits store but do nothing,
   // so the chip reset alarm can never be masked.
   assign live_alarms = alarm_q & ~(mask_ff & `SASR_MASK_LIVE);

   // unmasked alarm drives
   // Registered so the pin never glitches while flags and mask change together.
   always_ff @(posedge clk_in)
   begin
      if (!block_rst_b)
      begin
         alarm_ff <= 1'b0;
      end
      else
      begin
         alarm_ff <= |live_alarms;
      end
   end

   assign alarm_out = alarm_ff;

   // ==========================================================================
   // Read data
   // ==========================================================================

   // Masking is applied only at the output; reads show the raw alarm flags.
   // Unmapped addresses read as zero.
   assign rd_byte = hit_temp ? temp_pwr_ff :
                    hit_sync ? sync_read :
                    hit_alarm ? alarm_q :
                    hit_mask ? mask_ff : `SASR_RST_BYTE;

endmodule : sasr_sync_alarm_regs
`default_nettype wire

// [sasr_sync_alarm_regs_asserts.sv]
// Pin-level assertions for the sync status and system alarm register group.
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Checker module
module sasr_sync_alarm_regs_asserts (
   input wire logic clk_in, // Core clock.
   input wire logic rst_b_in, // Synchronous reset, active low.
   input wire logic soft_reset_in, // Software reset.
   input wire logic cs_b_in, // Chip select pin.
   input wire logic link_enable_in, // Link enabled.
   input wire logic link_down_in, // Link down seen.
   input wire logic link_timer_in, // Link timer expired.
   input wire logic [15:0] lane_enable_in, // Enabled lanes.
   input wire logic [15:0] lane_fault_in, // Lane check faults.
   input wire logic mode_64b66b_in, // 64b/66b coding.
   input wire logic div_misalign_in, // Divider misalignment.
   input wire logic link_misalign_in, // Link misalignment.
   input wire logic sdo_out, // Serial data out.
   input wire logic sdo_oe_out, // Serial drive enable.
   input wire logic temp_sensor_sleep_out, // Sensor sleep.
   input wire logic alarm_out // Alarm pin.
);
   logic alm_evt;

   // Any qualified alarm event; unqualified ones must never light the pin.
   assign alm_evt = div_misalign_in | (link_misalign_in & link_enable_in) | (link_down_in & link_enable_in)
      | link_timer_in | (mode_64b66b_in & (|(lane_fault_in & lane_enable_in)));

   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!rst_b_in);

   // A frame ends with chip select left high for a while.
   sequence cs_idle;
      cs_b_in [*8];
   endsequence
   sequence reset_released;
      $rose(rst_b_in);
   endsequence

   reset_alarm_a:
      assert property (reset_released |-> ##[1:2] alarm_out) else $error("alarm pin low after reset");
   soft_alarm_a:
      assert property (soft_reset_in |-> ##[1:3] alarm_out) else $error("alarm pin low after soft reset");
   // The pin may only rise two edges after a cause: event, register write or reset.
   rise_cause_a:
      assert property ($rose(alarm_out) |-> $past(alm_evt, 2) || !$past(cs_b_in, 6) || $past(soft_reset_in, 2)
         || !$past(rst_b_in, 2)) else $error("alarm pin rose without a cause");
   fall_cause_a:
      assert property ($fell(alarm_out) |-> !$past(cs_b_in, 6) || $past(soft_reset_in, 1)
         || $past(soft_reset_in, 2)) else $error("alarm pin fell without a write");
   sleep_write_a:
      assert property ($changed(temp_sensor_sleep_out) |-> !$past(cs_b_in, 6) || $past(soft_reset_in, 1)
         || $past(soft_reset_in, 2)) else $error("sensor sleep changed without a write");
   idle_quiet_a:
      assert property (cs_idle |-> !sdo_oe_out) else $error("serial output driven while idle");
   oe_start_a:
      assert property ($rose(sdo_oe_out) |-> !$past(cs_b_in, 3)) else $error("serial drive outside a frame");
   sdo_quiet_a:
      assert property ($changed(sdo_out) |-> sdo_oe_out || $past(sdo_oe_out)) else $error("serial data moved undriven");
endmodule : sasr_sync_alarm_regs_asserts

bind sasr_sync_alarm_regs sasr_sync_alarm_regs_asserts chk_u (.clk_in(clk_in), .rst_b_in(rst_b_in),
   .soft_reset_in(soft_reset_in), .cs_b_in(cs_b_in), .link_enable_in(link_enable_in), .link_down_in(link_down_in),
   .link_timer_in(link_timer_in), .lane_enable_in(lane_enable_in), .lane_fault_in(lane_fault_in),
   .mode_64b66b_in(mode_64b66b_in), .div_misalign_in(div_misalign_in), .link_misalign_in(link_misalign_in),
   .sdo_out(sdo_out), .sdo_oe_out(sdo_oe_out), .temp_sensor_sleep_out(temp_sensor_sleep_out), .alarm_out(alarm_out));
`default_nettype wire

// [sasr_sync_alarm_regs_tb_top.sv]
// Self-checking testbench for the sync status and system alarm register group.
`timescale 1ns/1ps
`default_nettype none
`include "sasr_defs.svh"
module sasr_sync_alarm_regs_tb_top;
   logic clk_in = 1'b0;
   logic rst_b_in = 1'b0;
   logic soft_reset_in = 1'b0;
   logic sclk_in = 1'b0;
   logic cs_b_in = 1'b1;
   logic sdi_in = 1'b0;
   logic ref_match_in = 1'b0;
   logic link_enable_in = 1'b0;
   logic mode_64b66b_in = 1'b0;
   logic [7:0] ev = 8'h00;
   logic [3:0] osc_pat = 4'h1;
   logic [15:0] lane_enable_in = 16'h0000;
   logic [15:0] fault_pat = 16'h0000;
   logic [15:0] lanes;
   logic sdo_out, sdo_oe_out, temp_sensor_sleep_out, alarm_out, slp;
   logic [7:0] rd_res, rnd;
   logic [1:0] pin_res;
   logic [7:0] rd_q[$];
   logic [1:0] pin_q[$];
   event rd_ev, pin_ev;
   int err_total = 0;
   int checks_done = 0;
   int unsigned src_tab[5] = '{6, 7, 3, 4, 5};
   int unsigned bit_tab[5] = '{0, 0, 7, 6, 5};

   // ==========================================
   // Clock and device
   always #2 clk_in = ~clk_in;

   sasr_sync_alarm_regs dut_u (.clk_in(clk_in), .rst_b_in(rst_b_in), .soft_reset_in(soft_reset_in),
      .sclk_in(sclk_in), .cs_b_in(cs_b_in), .sdi_in(sdi_in), .div_realign_in(ev[0]), .ref_pulse_in(ev[1]),
      .ref_match_in(ref_match_in), .osc_sync_in(ev[2] ? osc_pat : 4'h0), .link_enable_in(link_enable_in),
      .link_down_in(ev[3]), .link_timer_in(ev[4]), .lane_enable_in(lane_enable_in),
      .lane_fault_in(ev[5] ? fault_pat : 16'h0000), .mode_64b66b_in(mode_64b66b_in), .div_misalign_in(ev[6]),
      .link_misalign_in(ev[7]), .sdo_out(sdo_out), .sdo_oe_out(sdo_oe_out),
      .temp_sensor_sleep_out(temp_sensor_sleep_out), .alarm_out(alarm_out));

   // ==========================================
   // Drivers
   task automatic tick(input int n);
      repeat (n) @(posedge clk_in);
   endtask : tick

   // One 24-bit frame; sclk half periods of 10 cycles keep the pin filters clean.
   task automatic xfer(input logic rd, input logic [14:0] a, input logic [7:0] d);
      logic [23:0] fr;
      fr = {rd, a, d};
      tick(1);
      cs_b_in <= 1'b0;
      for (int i = 23; i >= 0; i--)
      begin
         tick(10);
         sclk_in <= 1'b0;
         sdi_in <= fr[i];
         tick(10);
         sclk_in <= 1'b1;
         if (i < 8)
            rd_res[i] = sdo_out;
      end
      tick(10);
      sclk_in <= 1'b0;
      tick(10);
      cs_b_in <= 1'b1;
      tick(10);
   endtask : xfer

   task automatic wr(input logic [14:0] a, input logic [7:0] d);
      xfer(1'b0, a, d);
   endtask : wr

   task automatic rd(input logic [14:0] a, input logic [7:0] e);
      rd_q.push_back(e);
      xfer(1'b1, a, 8'h00);
      ->rd_ev;
   endtask : rd

   // Pins are read a little after the edge so that the edge's updates have landed.
   task automatic pin(input logic a, input logic s);
      pin_q.push_back({a, s});
      tick(3);
      #1;
      pin_res = {alarm_out, temp_sensor_sleep_out};
      ->pin_ev;
      tick(1);
   endtask : pin

   task automatic fire(input int unsigned idx);
      ev[idx] <= 1'b1;
      tick(1);
      ev <= 8'h00;
      tick(1);
   endtask : fire

   // ==========================================
   // Result watchers
   task automatic cmp_byte(input logic [7:0] e, input logic [7:0] g);
      checks_done++;
      if (g !== e)
      begin
         err_total++;
         $display("CHECK FAILED t=%0t read %h expected %h", $time, g, e);
      end
   endtask : cmp_byte

   task automatic cmp_pin(input logic [1:0] e, input logic [1:0] g);
      checks_done++;
      if (g !== e)
      begin
         err_total++;
         $display("CHECK FAILED t=%0t alarm,sleep pins %b expected %b", $time, g, e);
      end
   endtask : cmp_pin

   always @(rd_ev) cmp_byte(rd_q.pop_front(), rd_res);
   always @(pin_ev) cmp_pin(pin_q.pop_front(), pin_res);

   task automatic tally_and_finish();
      if (err_total == 0 && checks_done > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : tally_and_finish

   // Watchdog sized well above the roughly 21k cycles the sequence needs.
   initial
   begin
      tick(60000);
      err_total++;
      $display("CHECK FAILED t=%0t watchdog expired", $time);
      tally_and_finish();
   end

   // ==========================================
   // Main sequence
   initial
   begin
      void'($urandom(32'ha7b2fa35));
      tick(8);
      rst_b_in <= 1'b1;
      tick(8);
      pin(1'b1, 1'b0);
      rd(`SASR_OFF_ALARM, `SASR_RST_ALARM);
      rd(`SASR_OFF_MASK, 8'h00);
      rd(`SASR_OFF_TEMP_PWR, 8'h00);
      rd(`SASR_OFF_SYNC, `SASR_RST_SYNC);
      wr(15'h7fff, 8'hff);
      rd(15'h0432, 8'h00);
      rnd = 8'($urandom);
      wr(`SASR_OFF_TEMP_PWR, rnd);
      pin(1'b1, rnd[0]);
      rd(`SASR_OFF_TEMP_PWR, rnd);
      slp = ~rnd[0];
      wr(`SASR_OFF_TEMP_PWR, {rnd[7:1], slp});
      wr(`SASR_OFF_ALARM, 8'hff);
      pin(1'b0, slp);
      rd(`SASR_OFF_ALARM, 8'h00);
      // Sync flags: all set, then the read-only consistency bit survives a clear.
      ref_match_in <= 1'b1;
      osc_pat <= 4'h1 << $urandom_range(3, 0);
      fire(0);
      fire(1);
      fire(2);
      pin(1'b0, slp);
      rd(`SASR_OFF_SYNC, 8'h0f);
      wr(`SASR_OFF_SYNC, 8'hff);
      rd(`SASR_OFF_SYNC, 8'h04);
      ref_match_in <= 1'b0;
      fire(1);
      rd(`SASR_OFF_SYNC, 8'h01);
      // Unqualified alarm events must leave everything clear.
      lanes = 16'($urandom) | 16'h0001;
      lane_enable_in <= lanes;
      fault_pat <= lanes;
      fire(3);
      fire(7);
      fire(5);
      mode_64b66b_in <= 1'b1;
      fault_pat <= ~lanes;
      fire(5);
      pin(1'b0, slp);
      rd(`SASR_OFF_ALARM, 8'h00);
      link_enable_in <= 1'b1;
      fault_pat <= lanes;
      // Each maskable alarm: masked, seen in the register, unmasked, cleared.
      for (int k = 0; k < 5; k++)
      begin
         wr(`SASR_OFF_MASK, 8'h01 << bit_tab[k]);
         fire(src_tab[k]);
         pin(1'b0, slp);
         rd(`SASR_OFF_ALARM, 8'h01 << bit_tab[k]);
         wr(`SASR_OFF_MASK, 8'h00);
         pin(1'b1, slp);
         wr(`SASR_OFF_ALARM, 8'h01 << bit_tab[k]);
         pin(1'b0, slp);
      end
      // A clear in the cycle of the last set loses.
      ev[6] <= 1'b1;
      fork
         wr(`SASR_OFF_ALARM, 8'h01);
         begin
            tick(487);
            ev <= 8'h00;
         end
      join
      rd(`SASR_OFF_ALARM, 8'h01);
      wr(`SASR_OFF_MASK, 8'hff);
      soft_reset_in <= 1'b1;
      tick(1);
      soft_reset_in <= 1'b0;
      pin(1'b1, 1'b0);
      rd(`SASR_OFF_MASK, 8'h00);
      rd(`SASR_OFF_ALARM, `SASR_RST_ALARM);
      tick(5);
      tally_and_finish();
   end
endmodule : sasr_sync_alarm_regs_tb_top
`default_nettype wire
